// ===== fcwd_regs.vh
// bit positions, reset values and encodings of the fieldbus command word
`ifndef FCWD_REGS_VH
`define FCWD_REGS_VH

`define FCWD_WORD_W 32
`define FCWD_INT_LOW_W 16
`define FCWD_WORD_RESET 32'h0000_0000
`define FCWD_UPPER_ZERO 16'h0000

`define FCWD_BIT_STOP 0
`define FCWD_BIT_START 1
`define FCWD_BIT_REVERSE 2
`define FCWD_BIT_FAULT_RESET 4
`define FCWD_BIT_EXT_LOC_B 5
`define FCWD_BIT_RUN_DISABLE 6
`define FCWD_BIT_STOP_NORMAL 7
`define FCWD_BIT_STOP_FAST 8
`define FCWD_BIT_STOP_FREE 9
`define FCWD_BIT_ACCEL_SET 10
`define FCWD_BIT_RAMP_OUT_ZERO 11
`define FCWD_BIT_RAMP_HOLD 12
`define FCWD_BIT_RAMP_IN_ZERO 13
`define FCWD_BIT_LOCAL_LOCK 14
`define FCWD_BIT_TAKE_CTL 16
`define FCWD_BIT_TAKE_REF 17
`define FCWD_USER_LSB 22
`define FCWD_USER_MSB 25
`define FCWD_USER_W 4
`define FCWD_USER_RESET 4'h0

`define FCWD_MASK_USED 32'h03C3_7FF7

`define FCWD_STOP_W 2
`define FCWD_STOP_NORMAL_RAMP 2'h0
`define FCWD_STOP_FAST_RAMP 2'h1
`define FCWD_STOP_FREEWHEEL 2'h2

`endif

// ===== fcwd_edge_pulse.v
// rising edge detector giving a one-cycle qualified pulse
`timescale 1ns/1ps
`default_nettype none

module fcwd_edge_pulse
(
	input wire i_clock,
	input wire i_rst,
	input wire i_level,
	input wire i_qualify,
	output reg o_pulse
);

	reg level_r;

	always @(posedge i_clock or posedge i_rst)
	begin
		if (i_rst)
		begin
			level_r <= 1'b0;
			o_pulse <= 1'b0;
		end
		else
		begin
			level_r <= i_level;
			o_pulse <= i_level & ~level_r & i_qualify;
		end
	end

endmodule

`default_nettype wire

// ===== fcwd_decoder.v
// fieldbus command word decoder turning word bits into drive commands
// Function
// - low sixteen bits passed unchanged internally
// - bit 0 stops, bit 1 starts
// - direction is reference sign xor bit 2
// - bit 4 rising edge clears active fault
// - bit 5 picks external location b when location source is bus
// - bit 6 set deasserts bus run enable
// - bits 7 to 9 pick stop mode
// - no request bit: configured stop mode
// - bit 10 clear selects first ramp pair
// - bit 11 forces ramp output zero
// - bit 12 holds ramp output
// - bit 13 forces ramp input zero
// - bit 14 blocks switch to local
// - bit 16 requests bus control takeover
// - bit 17 requests bus reference takeover
// - bits 22 to 25 forwarded user bits
// - no conversion or scaling of data
`timescale 1ns/1ps
`default_nettype none
`include "fcwd_regs.vh"

module fcwd_decoder
(
	input wire i_clock,
	input wire i_rst,
	input wire i_cmd_write,
	input wire [`FCWD_WORD_W-1:0] i_cmd_word,
	input wire i_ref_negative,
	input wire i_fault_active,
	input wire [`FCWD_STOP_W-1:0] i_cfg_stop_mode,
	input wire i_loc_src_is_bus,
	input wire i_loc_b_other,
	input wire i_run_src_is_bus,
	input wire i_run_enable_other,
	output wire [`FCWD_WORD_W-1:0] o_cmd_word,
	output reg [`FCWD_WORD_W-1:0] o_internal_word,
	output reg o_stop_cmd,
	output reg [`FCWD_STOP_W-1:0] o_stop_mode,
	output reg o_start_cmd,
	output reg o_dir_reverse,
	output wire o_fault_reset,
	output reg o_external_location_b,
	output reg o_run_enable,
	output reg o_accel_set_first,
	output reg o_ramp_out_zero,
	output reg o_ramp_hold,
	output reg o_ramp_in_zero,
	output reg o_local_lock,
	output reg o_bus_takeover_control,
	output reg o_bus_takeover_reference,
	output reg [`FCWD_USER_W-1:0] o_user_bits
);

	reg [`FCWD_WORD_W-1:0] fieldbus_command_word_r;
	reg [`FCWD_STOP_W-1:0] stop_mode_nxt;
	reg accel_first_nxt;
	wire [`FCWD_WORD_W-1:0] used_word;
	wire stop_sel_normal_ramp;
	wire stop_sel_fast_ramp;
	wire stop_sel_freewheel;

	// reserved positions are masked off before the bit decode; o_internal_word copies the low half unmasked
	assign used_word = fieldbus_command_word_r & `FCWD_MASK_USED;
	assign stop_sel_normal_ramp = used_word[`FCWD_BIT_STOP_NORMAL];
	assign stop_sel_fast_ramp = used_word[`FCWD_BIT_STOP_FAST];
	assign stop_sel_freewheel = used_word[`FCWD_BIT_STOP_FREE];
	assign o_cmd_word = fieldbus_command_word_r;

	// word stored exactly as written, no scaling
	always @(posedge i_clock or posedge i_rst)
	begin
		if (i_rst)
			fieldbus_command_word_r <= `FCWD_WORD_RESET;
		else if (i_cmd_write)
			fieldbus_command_word_r <= i_cmd_word;
	end

	// request bits choose the mode, safest wins when several set
	always @*
	begin
		if (stop_sel_freewheel)
			stop_mode_nxt = `FCWD_STOP_FREEWHEEL;
		else if (stop_sel_fast_ramp)
			stop_mode_nxt = `FCWD_STOP_FAST_RAMP;
		else if (stop_sel_normal_ramp)
			stop_mode_nxt = `FCWD_STOP_NORMAL_RAMP;
		else
			stop_mode_nxt = i_cfg_stop_mode;
	end

	// set bit is a no-op, so the previous pair choice stays
	always @*
	begin
		if (!used_word[`FCWD_BIT_ACCEL_SET])
			accel_first_nxt = 1'b1;
		else
			accel_first_nxt = o_accel_set_first;
	end

	always @(posedge i_clock or posedge i_rst)
	begin
		if (i_rst)
		begin
			o_internal_word <= `FCWD_WORD_RESET;
			o_stop_cmd <= 1'b0;
			o_stop_mode <= `FCWD_STOP_NORMAL_RAMP;
			o_start_cmd <= 1'b0;
			o_dir_reverse <= 1'b0;
			o_external_location_b <= 1'b0;
			o_run_enable <= 1'b0;
			o_accel_set_first <= 1'b1;
			o_ramp_out_zero <= 1'b0;
			o_ramp_hold <= 1'b0;
			o_ramp_in_zero <= 1'b0;
			o_local_lock <= 1'b0;
			o_bus_takeover_control <= 1'b0;
			o_bus_takeover_reference <= 1'b0;
			o_user_bits <= `FCWD_USER_RESET;
		end
		else
		begin
			o_internal_word <= {`FCWD_UPPER_ZERO,
				fieldbus_command_word_r[`FCWD_INT_LOW_W-1:0]};
			o_stop_cmd <= used_word[`FCWD_BIT_STOP];
			o_stop_mode <= stop_mode_nxt;
			o_start_cmd <= used_word[`FCWD_BIT_START];
			o_dir_reverse <= i_ref_negative ^ used_word[`FCWD_BIT_REVERSE];
			if (i_loc_src_is_bus)
				o_external_location_b <= used_word[`FCWD_BIT_EXT_LOC_B];
			else
				o_external_location_b <= i_loc_b_other;
			if (i_run_src_is_bus)
				o_run_enable <= ~used_word[`FCWD_BIT_RUN_DISABLE];
			else
				o_run_enable <= i_run_enable_other;
			o_accel_set_first <= accel_first_nxt;
			o_ramp_out_zero <= used_word[`FCWD_BIT_RAMP_OUT_ZERO];
			o_ramp_hold <= used_word[`FCWD_BIT_RAMP_HOLD];
			o_ramp_in_zero <= used_word[`FCWD_BIT_RAMP_IN_ZERO];
			o_local_lock <= used_word[`FCWD_BIT_LOCAL_LOCK];
			o_bus_takeover_control <= used_word[`FCWD_BIT_TAKE_CTL];
			o_bus_takeover_reference <= used_word[`FCWD_BIT_TAKE_REF];
			o_user_bits <= used_word[`FCWD_USER_MSB:`FCWD_USER_LSB];
		end
	end

	// edge of the stored reset bit, gated by an active fault
	fcwd_edge_pulse u_fault_reset
	(
		.i_clock(i_clock),
		.i_rst(i_rst),
		.i_level(used_word[`FCWD_BIT_FAULT_RESET]),
		.i_qualify(i_fault_active),
		.o_pulse(o_fault_reset)
	);

endmodule

`default_nettype wire

// ===== fcwd_props.sv
// assertions on the decoder ports
`timescale 1ns/1ps
`default_nettype none
module fcwd_props
(
	input wire i_clock,
	input wire i_rst,
	input wire i_fault_active,
	input wire [31:0] o_cmd_word,
	input wire [31:0] o_internal_word,
	input wire o_stop_cmd,
	input wire o_start_cmd,
	input wire o_fault_reset,
	input wire o_accel_set_first,
	input wire o_ramp_hold,
	input wire o_local_lock,
	input wire [3:0] o_user_bits
);
	default clocking @(posedge i_clock);
	endclocking
	default disable iff (i_rst);
	low_copy_a: assert property (o_internal_word == {16'h0000, $past(o_cmd_word[15:0])})
		else $error("low half");
	stop_cmd_a: assert property (o_stop_cmd == $past(o_cmd_word[0])) else $error("stop");
	start_cmd_a: assert property (o_start_cmd == $past(o_cmd_word[1])) else $error("start");
	fault_rst_a: assert property ($rose(o_cmd_word[4]) |=>
		o_fault_reset == $past(i_fault_active)) else $error("fault reset");
	ramp_set_a: assert property (!o_cmd_word[10] |=> o_accel_set_first) else $error("set");
	ramp_hold_a: assert property (o_ramp_hold == $past(o_cmd_word[12])) else $error("hold");
	lock_req_a: assert property (o_local_lock == $past(o_cmd_word[14])) else $error("lock");
	user_out_a: assert property (o_user_bits == $past(o_cmd_word[25:22]))
		else $error("user");
endmodule
bind fcwd_decoder fcwd_props i_props (.*);
`default_nettype wire

// ===== fcwd_master.sv
// fieldbus master model writing command words
`timescale 1ns/1ps
`default_nettype none
module fcwd_master
(
	input wire logic i_clock,
	output logic o_cmd_write,
	output logic [31:0] o_cmd_word
);
	initial o_cmd_write = 1'h0;
	initial o_cmd_word = 32'h0;
	task send(input logic [31:0] w);
		@(posedge i_clock);
		o_cmd_write <= 1'h1;
		o_cmd_word <= w;
		@(posedge i_clock);
		o_cmd_write <= 1'h0;
		o_cmd_word <= ~w;
	endtask
endmodule
`default_nettype wire

// ===== tb_top.sv
// decoder bench
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic i_clock = 1'h0, i_rst = 1'h1, i_cmd_write, i_ref_negative = 1'h1;
	logic i_fault_active = 1'h1, i_loc_src_is_bus = 1'h1, i_loc_b_other = 1'h0;
	logic i_run_src_is_bus = 1'h1, i_run_enable_other = 1'h1;
	logic [1:0] i_cfg_stop_mode = 2'h2;
	logic [31:0] i_cmd_word, o_cmd_word;
	wire [12:0] d;
	wire [5:0] u;
	int fails = 0, check_count = 0, cyc = 0, pulses = 0;
	always #5 i_clock = ~i_clock;
	fcwd_master i_mst (.i_clock, .o_cmd_write(i_cmd_write), .o_cmd_word(i_cmd_word));
	fcwd_decoder i_dut (.*, .o_internal_word(), .o_fault_reset(d[12]), .o_stop_cmd(d[11]),
		.o_start_cmd(d[10]), .o_dir_reverse(d[9]), .o_external_location_b(d[8]),
		.o_run_enable(d[7]), .o_accel_set_first(d[6]), .o_ramp_out_zero(d[5]),
		.o_ramp_in_zero(d[4]), .o_bus_takeover_control(d[3]), .o_bus_takeover_reference(d[2]),
		.o_stop_mode(d[1:0]), .o_ramp_hold(u[5]), .o_local_lock(u[4]), .o_user_bits(u[3:0]));
	task chk(input logic [31:0] g, input logic [31:0] e);
		check_count++;
		if (g !== e)
		begin
			fails++;
			$display("Error at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task run(input logic [31:0] w, input logic [11:0] e);
		i_mst.send(w);
		@(posedge i_clock);
		#1;
		chk(o_cmd_word, w);
		chk({20'h00000, d[11:0]}, {20'h00000, e});
	endtask
	task tally_and_finish;
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	always @(posedge i_clock)
	begin
		cyc++;
		pulses += (d[12] === 1'h1);
		if (cyc == 400)
		begin
			fails++;
			tally_and_finish;
		end
	end
	initial
	begin
		repeat (12) @(posedge i_clock);
		i_rst <= 1'h0;
		run(32'hFFFF_FFFF, 12'hD7E);
		run(32'h0000_0000, 12'h2C2);
		run(32'h0000_0181, 12'hAC1);
		@(posedge i_clock);
		i_fault_active <= 1'h0;
		i_cfg_stop_mode <= 2'h1;
		run(32'h0000_0091, 12'hAC0);
		@(posedge i_clock);
		{i_ref_negative, i_loc_src_is_bus, i_run_src_is_bus} <= 3'h0;
		{i_loc_b_other, i_run_enable_other} <= 2'h2;
		run(32'h0000_0004, 12'h341);
		run(32'h0240_5000, 12'h141);
		chk({26'h0000000, u}, 32'h0000_0039);
		chk(pulses, 32'h0000_0001);
		tally_and_finish;
	end
endmodule
`default_nettype wire
